// file: merr_bank.sv
`timescale 1ns/1ps
module merr_bank #(
  parameter logic [7:0] BANK_COUNT    = 8'h01,
  parameter logic       DEF_LOG_SUP   = 1'b1,
  parameter logic       DEF_CODE_SUP  = 1'b1
) (
  input  wire logic                        clk_sys,
  input  wire logic                        sys_rst,
  input  wire logic                        msr_wr,
  input  wire logic                        msr_rd,
  input  wire logic [merr_pkg::ADDR_W-1:0] msr_addr,
  input  wire logic [63:0]                 msr_wdata,
  output logic      [63:0]                 msr_rdata,
  output logic                             msr_ack,
  output logic                             msr_fault,
  input  wire logic                        exception_enable_bit,
  input  wire logic                        err_valid,
  input  wire logic                        err_uc,
  input  wire logic                        err_pcc,
  input  wire logic                        err_tcc,
  input  wire logic                        err_deferred,
  input  wire logic [15:0]                 err_code,
  input  wire logic [15:0]                 err_ext_code,
  input  wire logic                        err_addr_valid,
  input  wire logic [63:0]                 err_addr,
  input  wire logic                        err_synd_valid,
  input  wire logic [63:0]                 err_synd,
  input  wire logic [1:0][63:0]            err_synd_ext,
  input  wire logic [4:0][63:0]            err_misc,
  output logic                             mce_req,
  output logic                             core_shutdown,
  output logic                             deferred_irq,
  output logic                             threshold_irq,
  output merr_pkg::scope_t                 err_scope,
  output logic                             scope_valid
);
  import merr_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [63:0]      ctl;
    logic [63:0]      status;
    logic [63:0]      addr;
    logic [63:0]      cfg;
    logic [63:0]      synd;
    logic [63:0]      destat;
    logic [63:0]      deaddr;
    logic [63:0]      gctl;
    logic [15:0]      thr;
    logic [THR_W-1:0] ce_cnt;
    logic [4:0][63:0] misc;
    logic [1:0][63:0] synd_ext;
    core_mode_t       mode;
    logic             shut;
    logic [63:0]      rdata;
    logic             ack;
    logic             fault;
    logic             mce;
    logic             dirq;
    logic             tirq;
    logic             sv;
    scope_t           scope;
  } state_t;

  state_t s;
  state_t next_s;
  scope_t cls_scope;
  logic   rep_en;
  logic [63:0] destat_wmask;

  // Scope of the incoming error, registered only when an error arrives.
  merr_scope_classify u_classify (
    .processor_context_corrupt      (err_pcc),
    .thread_context_corrupt      (err_tcc),
    .uc       (err_uc),
    .deferred (err_deferred),
    .scope    (cls_scope)
  );

  // Reporting needs the global bit for this bank and some per-bank enable.
  assign rep_en = s.gctl[0] & (|s.ctl);
  // Deferred record code fields are reserved and read zero when the bank lacks code support.
  assign destat_wmask = DEF_CODE_SUP ? ~REG_RESET : ~CODE_MASK;

  // ----------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------
  // Returns {hit, data}; a miss answers zero with a fault pulse.
  function automatic logic [64:0] read_reg(input state_t st, input logic [ADDR_W-1:0] a);
    logic [63:0] cfg_ro;
    cfg_ro = REG_RESET;
    cfg_ro[CFG_DEFLOG_SUP] = DEF_LOG_SUP;
    cfg_ro[CFG_CODE_SUP] = DEF_CODE_SUP;
    read_reg = {1'b1, REG_RESET};
    case (a)
      OFS_CTL:    read_reg[63:0] = st.ctl;
      OFS_STATUS: read_reg[63:0] = st.status;
      OFS_ADDR:   read_reg[63:0] = st.addr;
      OFS_MISC0:  read_reg[63:0] = st.misc[0];
      OFS_CONFIG: read_reg[63:0] = st.cfg | cfg_ro;
      OFS_SYND:   read_reg[63:0] = st.synd;
      OFS_DESTAT: read_reg[63:0] = st.destat;
      OFS_DEADDR: read_reg[63:0] = st.deaddr;
      OFS_SYND1:  read_reg[63:0] = st.synd_ext[0];
      OFS_SYND2:  read_reg[63:0] = st.synd_ext[1];
      OFS_GCAP: begin
        read_reg[7:0] = BANK_COUNT;
        read_reg[GCAP_GLOBAL_CONTROL_PRESENT] = 1'b1;
      end
      OFS_GCTL:   read_reg[63:0] = st.gctl;
      OFS_THRESH: read_reg[63:0] = {36'h0, st.ce_cnt, st.thr};
      default: begin
        if (a >= OFS_MISC1 && a <= OFS_MISC4) begin
          read_reg[63:0] = st.misc[3'(a - OFS_MISC1) + 3'h1];
        end else begin
          read_reg[64] = 1'b0;
        end
      end
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Software writes are applied first and the error event second, so an
  // event landing in the cycle of a clear is kept rather than lost.
  always_comb begin
    logic [64:0] rd;
    rd = read_reg(s, msr_addr);
    next_s = s;
    next_s.ack = msr_rd | msr_wr;
    next_s.fault = 1'b0;
    next_s.mce = 1'b0;
    next_s.dirq = 1'b0;
    next_s.tirq = 1'b0;
    next_s.sv = 1'b0;
    if (msr_rd) begin
      next_s.rdata = rd[63:0];
      next_s.fault = ~rd[64];
    end
    if (msr_wr) begin
      case (msr_addr)
        OFS_CTL:    next_s.ctl = msr_wdata;
        OFS_STATUS: next_s.status = msr_wdata;
        OFS_ADDR:   next_s.addr = msr_wdata;
        OFS_MISC0:  next_s.misc[0] = msr_wdata;
        OFS_CONFIG: next_s.cfg = msr_wdata & CFG_WR_MASK;
        OFS_SYND:   next_s.synd = msr_wdata;
        OFS_DESTAT: next_s.destat = msr_wdata & destat_wmask;
        OFS_DEADDR: next_s.deaddr = msr_wdata;
        OFS_SYND1:  next_s.synd_ext[0] = msr_wdata;
        OFS_SYND2:  next_s.synd_ext[1] = msr_wdata;
        OFS_GCTL:   next_s.gctl = msr_wdata;
        OFS_THRESH: next_s.thr = msr_wdata[15:0];
        OFS_GCAP:   next_s.fault = 1'b1;
        default: begin
          if (msr_addr >= OFS_MISC1 && msr_addr <= OFS_MISC4) begin
            next_s.misc[3'(msr_addr - OFS_MISC1) + 3'h1] = msr_wdata;
          end else begin
            next_s.fault = 1'b1;
          end
        end
      endcase
    end
    if (err_valid) begin
      next_s.scope = cls_scope;
      next_s.sv = 1'b1;
      // Deferred record: first error wins, later ones only flag overflow.
      if (err_deferred && DEF_LOG_SUP) begin
        if (next_s.destat[ST_VALID]) begin
          next_s.destat[ST_OVER] = 1'b1;
        end else begin
          next_s.destat = REG_RESET;
          next_s.destat[ST_VALID] = 1'b1;
          next_s.destat[ST_DEFER] = 1'b1;
          next_s.destat[ST_ADDRESS_VALID_FLAG] = err_addr_valid;
          next_s.destat[ST_SYNDROME_VALID_FLAG] = err_synd_valid;
          next_s.destat[31:0] = {err_ext_code, err_code} & destat_wmask[31:0];
          next_s.deaddr = err_addr;
          next_s.misc[4:1] = err_misc[4:1];
          if (err_synd_valid) begin
            next_s.synd = err_synd;
            next_s.synd_ext = err_synd_ext;
          end
        end
        if (rep_en && s.cfg[CFG_INT_LO +: 2] == INT_APIC) begin
          next_s.dirq = 1'b1;
        end
      end
      // Primary record takes every non-deferred error, and deferred ones
      // only when dual logging is on or the bank cannot log them apart.
      if (!err_deferred || !DEF_LOG_SUP || s.cfg[CFG_DUAL_LOG]) begin
        if (next_s.status[ST_VALID]) begin
          next_s.status[ST_OVER] = 1'b1;
        end else begin
          next_s.status = REG_RESET;
          next_s.status[ST_VALID] = 1'b1;
          next_s.status[ST_UC] = err_uc;
          next_s.status[ST_PCC] = err_pcc;
          next_s.status[ST_TCC] = err_tcc;
          next_s.status[ST_MISCV] = 1'b1;
          next_s.status[ST_ADDRESS_VALID_FLAG] = err_addr_valid;
          next_s.status[ST_SYNDROME_VALID_FLAG] = err_synd_valid;
          next_s.status[ST_DEFER] = err_deferred;
          next_s.status[31:0] = {err_ext_code, err_code};
          next_s.addr = err_addr;
          next_s.misc = err_misc;
          if (err_synd_valid) begin
            next_s.synd = err_synd;
            next_s.synd_ext = err_synd_ext;
          end
        end
      end
      // Uncorrected errors: exception when allowed, otherwise shutdown.
      if (err_uc && rep_en && s.mode == MODE_RUN) begin
        if (exception_enable_bit) begin
          next_s.mce = 1'b1;
        end else begin
          // A flag of its own keeps the shutdown output a plain flop.
          next_s.mode = MODE_SHUT;
          next_s.shut = 1'b1;
        end
      end
      // Corrected errors count toward the programmed threshold.
      if (!err_uc && !err_deferred && s.thr[THR_EN]) begin
        if (s.ce_cnt + CNT_ONE >= s.thr[THR_W-1:0]) begin
          next_s.ce_cnt = '0;
          next_s.tirq = rep_en;
        end else begin
          next_s.ce_cnt = s.ce_cnt + CNT_ONE;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset clears every enable so nothing is reported until software opts in.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
      s.mode <= MODE_RUN;
      s.scope <= SCOPE_CORR;
    end else begin
      s <= next_s;
    end
  end

  // Every output is a field of the registered state.
  assign msr_rdata     = s.rdata;
  assign msr_ack       = s.ack;
  assign msr_fault     = s.fault;
  assign mce_req       = s.mce;
  assign core_shutdown = s.shut;
  assign deferred_irq  = s.dirq;
  assign threshold_irq = s.tirq;
  assign err_scope     = s.scope;
  assign scope_valid   = s.sv;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  // Software writes that race an error in the same cycle.
  logic de_wr;
  logic new_def;
  logic st_wr;
  assign de_wr = msr_wr && msr_addr == OFS_DESTAT;
  assign st_wr = msr_wr && msr_addr == OFS_STATUS;
  assign new_def = err_valid && err_deferred && DEF_LOG_SUP && !s.destat[ST_VALID] && !de_wr;

  // Deferred record checks.
  a_defer_logged: assert property (new_def |=> s.destat[ST_VALID] && s.destat[ST_DEFER])
    else $error("deferred error not logged");
  a_defer_bits: assert property (new_def |=> s.destat[ST_ADDRESS_VALID_FLAG] == $past(err_addr_valid)
                                 && s.destat[ST_SYNDROME_VALID_FLAG] == $past(err_synd_valid)
                                 && s.deaddr == $past(err_addr))
    else $error("deferred flags not set with record");
  a_defer_overflow: assert property (err_valid && err_deferred && s.destat[ST_VALID] && !de_wr
                                     |=> s.destat[ST_OVER] && s.destat[43:0] == $past(s.destat[43:0]))
    else $error("deferred overflow wrong");
  a_defer_kept: assert property (err_valid && !err_deferred && s.destat[ST_VALID] && !de_wr
                                 |=> $stable(s.destat))
    else $error("deferred record disturbed");

  // Primary record and core response checks.
  a_clear_zero: assert property (msr_wr && msr_addr == OFS_STATUS && msr_wdata == REG_RESET && !err_valid
                                 |=> s.status == REG_RESET)
    else $error("status not cleared");
  a_shut_down: assert property (err_valid && err_uc && rep_en && !exception_enable_bit
                                |=> core_shutdown [*2])
    else $error("no shutdown");
  a_mce_pulse: assert property (err_valid && err_uc && rep_en && exception_enable_bit && !core_shutdown
                                |=> mce_req ##1 !mce_req || $past(err_valid))
    else $error("exception not raised");

  // Scope classification of fatal and recoverable errors.
  a_fatal_scope: assert property (err_valid && err_uc && err_pcc
                                  |=> scope_valid && err_scope == SCOPE_FATAL)
    else $error("fatal scope wrong");
  a_recov_scope: assert property (err_valid && err_uc && !err_pcc && !err_tcc
                                  |=> err_scope == SCOPE_RECOV)
    else $error("recoverable scope wrong");

  // Nothing is reported while the enables are off, whatever gets logged.
  a_quiet_off: assert property (!rep_en |=> !mce_req && !deferred_irq && !threshold_irq)
    else $error("report while disabled");
  // The deferred interrupt follows every deferred error while reporting is enabled and the type selects it.
  a_defer_irq: assert property (err_valid && err_deferred && DEF_LOG_SUP && rep_en
                                && s.cfg[CFG_INT_LO +: 2] == INT_APIC |=> deferred_irq)
    else $error("deferred interrupt missing");
  // The threshold interrupt only ever answers a corrected error.
  a_thresh_src: assert property (threshold_irq |-> $past(err_valid && !err_uc && !err_deferred))
    else $error("threshold interrupt without corrected error");
  // Dual logging also lands a deferred error in an empty primary record.
  a_dual_log: assert property (err_valid && err_deferred && s.cfg[CFG_DUAL_LOG] && !s.status[ST_VALID]
                               && !st_wr |=> s.status[ST_VALID] && s.status[ST_DEFER])
    else $error("dual logging missing");
  // Codes of a fresh deferred record are the incoming ones when supported.
  a_defer_code: assert property (new_def && DEF_CODE_SUP
                                 |=> s.destat[31:0] == $past({err_ext_code, err_code}))
    else $error("deferred codes wrong");
  // Syndrome data of a fresh deferred record is the incoming one when flagged valid.
  a_defer_synd: assert property (new_def && err_synd_valid |=> s.synd == $past(err_synd))
    else $error("deferred syndrome wrong");
  // A core in shutdown never asks for the exception again.
  a_shut_quiet: assert property (core_shutdown |-> !mce_req)
    else $error("exception during shutdown");

  // Main scenarios that the bench is expected to reach.
  c_defer_log: cover property (new_def ##1 deferred_irq);
  c_overflow: cover property (s.destat[ST_VALID] && err_valid && err_deferred ##1 s.destat[ST_OVER]);
  c_threshold: cover property (threshold_irq);
  c_shutdown: cover property ($rose(core_shutdown));
  c_dual_log: cover property (err_valid && err_deferred && s.cfg[CFG_DUAL_LOG]);
endmodule

// file: merr_bank_tb.sv
`timescale 1ns/1ps
module merr_bank_tb;
  import merr_pkg::*;

  // ----------------------------------------------------------------
  // Signals of the bank under test
  // ----------------------------------------------------------------
  localparam logic [7:0] BANKS = 8'h03;
  logic                    clk_sys              = 1'b0;
  logic                    sys_rst              = 1'b1;
  logic                    msr_wr               = 1'b0;
  logic                    msr_rd               = 1'b0;
  logic [ADDR_W-1:0]       msr_addr             = 16'h0000;
  logic [63:0]             msr_wdata            = 64'h0;
  logic [63:0]             msr_rdata;
  logic                    msr_ack;
  logic                    msr_fault;
  logic                    exception_enable_bit = 1'b0;
  logic                    err_valid            = 1'b0;
  logic                    err_uc               = 1'b0;
  logic                    err_pcc              = 1'b0;
  logic                    err_tcc              = 1'b0;
  logic                    err_deferred         = 1'b0;
  logic [15:0]             err_code             = 16'h0000;
  logic [15:0]             err_ext_code         = 16'h0000;
  logic                    err_addr_valid       = 1'b0;
  logic [63:0]             err_addr             = 64'h0;
  logic                    err_synd_valid       = 1'b0;
  logic [63:0]             err_synd             = 64'h0;
  logic [1:0][63:0]        err_synd_ext         = '0;
  logic [4:0][63:0]        err_misc             = '0;
  logic                    mce_req;
  logic                    core_shutdown;
  logic                    deferred_irq;
  logic                    threshold_irq;
  scope_t                  err_scope;
  logic                    scope_valid;
  int                      mismatches           = 0;
  int                      comparisons          = 0;
  logic [31:0]             lfsr                 = 32'h0000_0048;
  logic [15:0]             c_code;
  logic [15:0]             c_ext;
  logic                    c_av;
  logic                    c_sv;
  logic [63:0]             c_addr;
  logic [63:0]             c_synd;
  logic [1:0][63:0]        c_sx;
  logic [4:0][63:0]        c_misc;
  logic [63:0]             keep;
  logic [63:0]             v;

  // Free-running system clock, 8 ns period.
  always #4 clk_sys = ~clk_sys;

  merr_bank #(
    .BANK_COUNT(BANKS)
  ) merr_bank_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .msr_wr(msr_wr), .msr_rd(msr_rd),
    .msr_addr(msr_addr), .msr_wdata(msr_wdata), .msr_rdata(msr_rdata),
    .msr_ack(msr_ack), .msr_fault(msr_fault), .exception_enable_bit(exception_enable_bit),
    .err_valid(err_valid), .err_uc(err_uc), .err_pcc(err_pcc), .err_tcc(err_tcc),
    .err_deferred(err_deferred), .err_code(err_code), .err_ext_code(err_ext_code),
    .err_addr_valid(err_addr_valid), .err_addr(err_addr), .err_synd_valid(err_synd_valid),
    .err_synd(err_synd), .err_synd_ext(err_synd_ext), .err_misc(err_misc),
    .mce_req(mce_req), .core_shutdown(core_shutdown), .deferred_irq(deferred_irq),
    .threshold_irq(threshold_irq), .err_scope(err_scope), .scope_valid(scope_valid)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Pseudo-random source, fixed start so every run repeats.
  function automatic logic [63:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    rnd[63:32] = lfsr;
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    rnd[31:0] = lfsr;
  endfunction

  // Expected deferred record; model-dependent bits are left at zero.
  function automatic logic [63:0] exp_record(input logic ov, input logic av, input logic sv);
    logic [63:0] r;
    r = REG_RESET;
    r[ST_VALID] = 1'b1;
    r[ST_OVER] = ov;
    r[ST_ADDRESS_VALID_FLAG] = av;
    r[ST_SYNDROME_VALID_FLAG] = sv;
    r[ST_DEFER] = 1'b1;
    r[31:0] = {c_ext, c_code};
    return r;
  endfunction

  task automatic chk(input string what, input logic [63:0] e, input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  // One register access; request held until the edge that samples it, answer looked at 1 ns after that same edge.
  task automatic access(input logic w, input logic [15:0] a, input logic [63:0] wd, input logic flt,
                        output logic [63:0] rd);
    @(posedge clk_sys);
    msr_wr <= w;
    msr_rd <= !w;
    msr_addr <= a;
    msr_wdata <= wd;
    @(posedge clk_sys);
    msr_wr <= 1'b0;
    msr_rd <= 1'b0;
    #1;
    chk("ack", 64'h1, {63'h0, msr_ack});
    chk("fault", {63'h0, flt}, {63'h0, msr_fault});
    rd = msr_rdata;
  endtask

  task automatic rd_chk(input string n, input logic [15:0] a, input logic [63:0] e);
    logic [63:0] r;
    access(1'b0, a, 64'h0, 1'b0, r);
    chk(n, e, r);
  endtask

  task automatic wr(input logic [15:0] a, input logic [63:0] d);
    logic [63:0] r;
    access(1'b1, a, d, 1'b0, r);
  endtask

  task automatic draw;
    logic [63:0] r;
    r = rnd();
    c_code = r[15:0];
    c_ext = r[31:16];
    c_av = r[40];
    c_sv = r[41];
    c_addr = rnd();
    c_synd = rnd();
    c_sx[0] = rnd();
    c_sx[1] = rnd();
    for (int k = 0; k < 5; k++) c_misc[k] = rnd();
  endtask

  // One error event; outputs are pulses, so they are looked at in the one cycle they stand.
  task automatic fire(input logic uc, input logic processor_context_corrupt, input logic thread_context_corrupt, input logic dfr, input scope_t sc);
    @(posedge clk_sys);
    err_valid <= 1'b1;
    err_uc <= uc;
    err_pcc <= processor_context_corrupt;
    err_tcc <= thread_context_corrupt;
    err_deferred <= dfr;
    err_code <= c_code;
    err_ext_code <= c_ext;
    err_addr_valid <= c_av;
    err_addr <= c_addr;
    err_synd_valid <= c_sv;
    err_synd <= c_synd;
    err_synd_ext <= c_sx;
    err_misc <= c_misc;
    @(posedge clk_sys);
    err_valid <= 1'b0;
    #1;
    chk("scope valid", 64'h1, {63'h0, scope_valid});
    chk("scope", {61'h0, sc}, {61'h0, err_scope});
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // A hang in any handshake ends the run here as a failure.
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd_chk("control", OFS_CTL, REG_RESET);
    rd_chk("global control", OFS_GCTL, REG_RESET);
    rd_chk("deferred record", OFS_DESTAT, REG_RESET);
    rd_chk("config", OFS_CONFIG, 64'h0000_0000_0000_0084);
    access(1'b1, OFS_GCAP, 64'hFFFF_FFFF_FFFF_FFFF, 1'b1, v);
    rd_chk("capability", OFS_GCAP, {55'h0, 1'b1, BANKS});
    access(1'b0, 16'h0005, 64'h0, 1'b1, v);
    chk("unmapped", 64'h0, v);
    // Software enables everything; deferred interrupt type 01.
    wr(OFS_GCTL, 64'hFFFF_FFFF_FFFF_FFFF);
    wr(OFS_CTL, 64'hFFFF_FFFF_FFFF_FFFF);
    wr(OFS_CONFIG, 64'h0000_0020_0000_0000);
    rd_chk("config", OFS_CONFIG, 64'h0000_0020_0000_0084);
    for (int i = 0; i < 4; i++) begin
      draw();
      if (i == 0) begin
        c_code = 16'hFFFF;
        c_ext = 16'h0000;
        c_av = 1'b1;
        c_sv = 1'b1;
      end
      fire(1'b0, 1'b0, 1'b0, 1'b1, SCOPE_DEFER);
      chk("deferred irq", 64'h1, {63'h0, deferred_irq});
      chk("mce on deferred", 64'h0, {63'h0, mce_req});
      rd_chk("deferred record", OFS_DESTAT, exp_record(1'b0, c_av, c_sv));
      if (c_av) rd_chk("deferred address", OFS_DEADDR, c_addr);
      for (int j = 1; j < 5; j++) rd_chk("misc", OFS_MISC1 + 16'(j - 1), c_misc[j]);
      if (c_sv) begin
        rd_chk("syndrome", OFS_SYND, c_synd);
        rd_chk("syndrome 1", OFS_SYND1, c_sx[0]);
        rd_chk("syndrome 2", OFS_SYND2, c_sx[1]);
      end
      rd_chk("primary status", OFS_STATUS, REG_RESET);
      keep = exp_record(1'b0, c_av, c_sv);
      if (i < 3) begin
        wr(OFS_DESTAT, REG_RESET);
        rd_chk("cleared record", OFS_DESTAT, REG_RESET);
      end
    end
    // A second deferred error must not displace the one still held.
    draw();
    fire(1'b0, 1'b0, 1'b0, 1'b1, SCOPE_DEFER);
    keep[ST_OVER] = 1'b1;
    rd_chk("overflow record", OFS_DESTAT, keep);
    @(posedge clk_sys);
    exception_enable_bit <= 1'b1;
    fire(1'b1, 1'b1, 1'b0, 1'b0, SCOPE_FATAL);
    chk("mce fatal", 64'h1, {63'h0, mce_req});
    rd_chk("record kept", OFS_DESTAT, keep);
    fire(1'b1, 1'b0, 1'b0, 1'b0, SCOPE_RECOV);
    chk("mce recoverable", 64'h1, {63'h0, mce_req});
    wr(OFS_STATUS, REG_RESET);
    rd_chk("status cleared", OFS_STATUS, REG_RESET);
    // Dual logging on: a deferred error lands in the primary record as well.
    wr(OFS_CONFIG, 64'h0000_0024_0000_0000);
    wr(OFS_DESTAT, REG_RESET);
    draw();
    fire(1'b0, 1'b0, 1'b0, 1'b1, SCOPE_DEFER);
    rd_chk("dual status", OFS_STATUS, exp_record(1'b0, c_av, c_sv) | (64'h1 << ST_MISCV));
    // Threshold of two corrected errors: only the second one interrupts.
    wr(OFS_THRESH, 64'h0000_0000_0000_8002);
    fire(1'b0, 1'b0, 1'b0, 1'b0, SCOPE_CORR);
    chk("threshold early", 64'h0, {63'h0, threshold_irq});
    fire(1'b0, 1'b0, 1'b0, 1'b0, SCOPE_CORR);
    chk("threshold reached", 64'h1, {63'h0, threshold_irq});
    // Exception disabled: an uncorrected error shuts the core down.
    @(posedge clk_sys);
    exception_enable_bit <= 1'b0;
    fire(1'b1, 1'b0, 1'b0, 1'b0, SCOPE_RECOV);
    chk("shutdown", 64'h1, {63'h0, core_shutdown});
    chk("mce in shutdown", 64'h0, {63'h0, mce_req});
    close_out();
  end
endmodule

// file: merr_pkg.sv
package merr_pkg;

  // ----------------------------------------------------------------
  // Register index map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam logic [15:0] OFS_CTL    = 16'h0000;
  localparam logic [15:0] OFS_STATUS = 16'h0001;
  localparam logic [15:0] OFS_ADDR   = 16'h0002;
  localparam logic [15:0] OFS_MISC0  = 16'h0003;
  localparam logic [15:0] OFS_CONFIG = 16'h0004;
  localparam logic [15:0] OFS_SYND   = 16'h0006;
  localparam logic [15:0] OFS_DESTAT = 16'h0008;
  localparam logic [15:0] OFS_DEADDR = 16'h0009;
  localparam logic [15:0] OFS_MISC1  = 16'h000A;
  localparam logic [15:0] OFS_MISC4  = 16'h000D;
  localparam logic [15:0] OFS_SYND1  = 16'h000E;
  localparam logic [15:0] OFS_SYND2  = 16'h000F;
  localparam logic [15:0] OFS_GCAP   = 16'h0100;
  localparam logic [15:0] OFS_GCTL   = 16'h0101;
  localparam logic [15:0] OFS_THRESH = 16'h0102;

  // ----------------------------------------------------------------
  // Status record fields
  // ----------------------------------------------------------------
  localparam int ST_VALID = 63;
  localparam int ST_OVER  = 62;
  localparam int ST_UC    = 61;
  localparam int ST_MISCV = 59;
  localparam int ST_ADDRESS_VALID_FLAG = 58;
  localparam int ST_PCC   = 57;
  localparam int ST_TCC   = 55;
  localparam int ST_SYNDROME_VALID_FLAG = 53;
  localparam int ST_DEFER = 44;
  localparam logic [63:0] CODE_MASK = 64'h0000_0000_FFFF_FFFF;
  localparam logic [63:0] REG_RESET = 64'h0000_0000_0000_0000;

  // ----------------------------------------------------------------
  // Configuration, capability and threshold fields
  // ----------------------------------------------------------------
  localparam int CFG_DEFLOG_SUP = 2;
  localparam int CFG_CODE_SUP   = 7;
  localparam int CFG_DUAL_LOG   = 34;
  localparam int CFG_INT_LO     = 37;
  localparam logic [63:0] CFG_WR_MASK = 64'h0000_0065_0000_0200;
  localparam logic [1:0]  INT_APIC    = 2'h1;
  localparam int GCAP_GLOBAL_CONTROL_PRESENT = 8;
  localparam int THR_EN    = 15;
  localparam int THR_W     = 12;
  localparam logic [11:0] CNT_ONE = 12'h001;

  typedef enum logic [1:0] {
    MODE_RUN  = 2'h1,
    MODE_SHUT = 2'h2
  } core_mode_t;

  typedef enum logic [2:0] {
    SCOPE_FATAL   = 3'h1,
    SCOPE_RECOV   = 3'h2,
    SCOPE_CONTAIN = 3'h3,
    SCOPE_DEFER   = 3'h4,
    SCOPE_CORR    = 3'h5
  } scope_t;

endpackage

// file: merr_scope_classify.sv
`timescale 1ns/1ps
module merr_scope_classify (
  input  wire logic            processor_context_corrupt,
  input  wire logic            thread_context_corrupt,
  input  wire logic            uc,
  input  wire logic            deferred,
  output merr_pkg::scope_t     scope
);
  import merr_pkg::*;

  // Context-corrupt bits decide how far an uncorrected error reaches.
  always_comb begin
    if (uc && processor_context_corrupt) begin
      scope = SCOPE_FATAL;
    end else if (uc && !thread_context_corrupt) begin
      scope = SCOPE_RECOV;
    end else if (uc) begin
      scope = SCOPE_CONTAIN;
    end else if (deferred) begin
      scope = SCOPE_DEFER;
    end else begin
      scope = SCOPE_CORR;
    end
  end
endmodule
